// File: design/sirq_slave.sv
// Purpose: Slave agent reporting interrupt levels over the serial interrupt wire.
// Assumes: Host runs frames as below; all inputs synchronous to sys_clk_i.
// Notes:   Quiet mode lets this end start cycles when a reported level changes.
// Overview of operation
// R1: Quiet start: one low clock, then release.
// R2: Never start while a cycle is active.
// R3: Host stretches start low to 4-8 clocks.
// R4: Level change in quiet mode requests start.
// R5: Continuous mode: slave never starts frames.
// R6: Host may run cycles back to back.
// R7: Mode changes only at a Stop Frame.
// R8: After reset continuous; host starts first cycle.
// R9: Measure Stop width to pick next mode.
// R10: Count three-clock frames from start rise.
// R11: Sample phase: drive low if level low.
// R12: Recovery: drive high after driving low.
// R13: Turn-around: always release the wire.
// R14: Report in every cycle, whoever started it.
// R15: Frame n samples 3n-1 clocks after rise.
// R16: Periods 1..16 carry unused, IRQ1..IRQ15.
// R17: Enable bits steer management request slot/pin.
// R18: Period 14 carries IRQ13.
// R19: Host ends cycles with 2 or 3 clock Stop.
// R20: Two-clock Stop: quiet, start two clocks on.
// R21: Three-clock Stop: continuous, host starts only.
// R22: Reset releases wire, slave to continuous idle.
// R23: Drive and sample on rising clock edge.
// R24: Captured level per line drives slots, requests.
`timescale 1ns/10ps
module sirq_slave (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  sirq_if.slave                              link,
  input  wire logic [sirq_pkg::SLOT_CNT-1:0] irq_level_i,
  input  wire logic                          mgmt_interrupt_request_n_i,
  input  wire logic [7:0]                    mgmt_enable2_i,
  output logic                               mgmt_interrupt_n_o,
  output logic                               quiet_mode_o,
  output logic                               cycle_active_o
);
  sirq_pkg::sirq_slv_state_t         state_reg;
  sirq_pkg::sirq_cnt_t               cnt_reg;
  sirq_pkg::sirq_cnt_t               gap_reg;
  sirq_pkg::sirq_cnt_t               pos_next;
  sirq_pkg::sirq_cnt_t               sample_slot;
  logic [sirq_pkg::SLOT_IDX_W-1:0]   sample_idx;
  logic [sirq_pkg::SLOT_CNT-1:0]     slot_vec;
  logic [sirq_pkg::SLOT_CNT-1:0]     level_reg;
  logic [sirq_pkg::SLOT_CNT-1:0]     pend_reg;
  logic [sirq_pkg::SLOT_CNT-1:0]     pend_clr;
  logic                              quiet_reg;
  logic                              drv_reg;
  logic                              oe_reg;
  logic                              rise;
  sirq_pkg::sirq_width_t             width;
  logic                              in_frames;
  logic                              sample_now;
  logic                              recov_now;
  logic                              start_go;
  logic                              stop_seen;

  sirq_low_meter u_meter (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .line_i    (link.line),
    .rise_o    (rise),
    .width_o   (width)
  );

  // Slot vector in period order; the management request may take period 3.
  always_comb begin
    slot_vec = irq_level_i;
    slot_vec[sirq_pkg::UNUSED_SLOT] = 1'b1;
    if (mgmt_enable2_i[sirq_pkg::SMI_SERIAL_BIT]) begin
      slot_vec[sirq_pkg::SMI_SLOT] = mgmt_interrupt_request_n_i; // R17
    end
  end

  // Decisions are made one clock ahead, so the position is that of the next clock.
  assign pos_next    = cnt_reg + 8'h01;
  assign sample_slot = sirq_pkg::frame_slot(pos_next); // R15
  assign sample_idx  = sample_slot[sirq_pkg::SLOT_IDX_W-1:0];
  assign in_frames   = (state_reg == sirq_pkg::SL_FRAMES);
  assign sample_now  = in_frames && (sirq_pkg::frame_phase(pos_next) == sirq_pkg::PH_SAMPLE)
                       && (sample_slot < sirq_pkg::SLOT_LIMIT); // R16 R18
  assign recov_now   = in_frames && (sirq_pkg::frame_phase(pos_next) == sirq_pkg::PH_RECOV);
  assign start_go    = (state_reg == sirq_pkg::SL_IDLE) && quiet_reg && link.line // R2 R5
                       && (gap_reg >= sirq_pkg::GAP_MIN) && (|pend_reg); // R4 R20
  assign stop_seen   = in_frames && rise && (width >= sirq_pkg::STOP_QUIET_W); // R9

  always_comb begin
    pend_clr = '0;
    if (sample_now) begin
      pend_clr[sample_idx] = 1'b1;
    end
  end

  // A change seen after its own sample clock stays pending, so in quiet mode it
  // asks for a new cycle once the Stop has passed.
  // Captured levels; a change is pending until its slot has been sampled.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_reg <= '1;
      pend_reg  <= '0;
    end else begin
      level_reg <= slot_vec; // R24
      pend_reg  <= (pend_reg & ~pend_clr) | (slot_vec ^ level_reg); // R4 R24
    end
  end

  // Any low level while idle is taken as a start, so cycles begun by the host
  // and by this end are followed in the same way.
  // Cycle tracking: idle, start pulse seen, frames counted from the start rise.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= sirq_pkg::SL_IDLE; // R22
      cnt_reg   <= '0;
    end else begin
      unique case (state_reg)
        sirq_pkg::SL_IDLE: begin
          if (!link.line) begin
            state_reg <= sirq_pkg::SL_START; // R14
          end
        end
        sirq_pkg::SL_START: begin
          if (rise) begin
            state_reg <= sirq_pkg::SL_FRAMES; // R10
            cnt_reg   <= 8'h01;
          end
        end
        sirq_pkg::SL_FRAMES: begin
          if (stop_seen) begin
            state_reg <= sirq_pkg::SL_IDLE; // R19
          end else if (cnt_reg != sirq_pkg::CNT_MAX) begin
            cnt_reg <= pos_next; // R10
          end
        end
        default: begin
          state_reg <= sirq_pkg::SL_IDLE;
        end
      endcase
    end
  end

  // A Stop of three clocks or more counts as continuous, so a stretched Stop
  // never lets this end begin cycles of its own.
  // Next-cycle mode comes from the width of each Stop pulse.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_reg <= 1'b0; // R8 R22
    end else if (stop_seen) begin
      quiet_reg <= (width == sirq_pkg::STOP_QUIET_W); // R7 R9 R20 R21
    end
  end

  // The gap restarts in the rise clock itself, so the earliest own start falls
  // one clock later than allowed; this costs latency, never correctness.
  // Clocks since the Stop rise; a start is allowed from the second clock on.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_reg <= sirq_pkg::CNT_MAX;
    end else if (stop_seen) begin
      gap_reg <= '0;
    end else if (gap_reg != sirq_pkg::CNT_MAX) begin
      gap_reg <= gap_reg + 8'h01; // R20
    end
  end

  // Drive and enable come only from flip-flops, so the wire changes just after
  // a rising edge and is settled at the next one.
  // Wire drive, registered on the rising edge; released unless a phase needs it.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_reg  <= 1'b0; // R22
      drv_reg <= 1'b1;
    end else begin
      oe_reg  <= 1'b0; // R13 R23
      drv_reg <= 1'b1;
      if (start_go) begin
        oe_reg  <= 1'b1; // R1
        drv_reg <= 1'b0;
      end else if (sample_now && !level_reg[sample_idx]) begin
        oe_reg  <= 1'b1; // R11 R14
        drv_reg <= 1'b0;
      end else if (recov_now && oe_reg && !drv_reg) begin
        oe_reg  <= 1'b1; // R12
        drv_reg <= 1'b1;
      end
    end
  end

  // Dedicated management pin and status outputs.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mgmt_interrupt_n_o <= 1'b1;
      cycle_active_o     <= 1'b0;
    end else begin
      mgmt_interrupt_n_o <= mgmt_enable2_i[sirq_pkg::SMI_PIN_BIT] ?
                            mgmt_interrupt_request_n_i : 1'b1; // R17
      cycle_active_o     <= (state_reg != sirq_pkg::SL_IDLE);
    end
  end

  assign quiet_mode_o   = quiet_reg;
  assign link.slave_oe  = oe_reg;
  assign link.slave_drv = drv_reg;
endmodule

// File: design/sirq_pkg.sv
// Purpose: Shared constants, types and frame decoding for the serial interrupt link.
// Assumes: One link clock; all counts are in clocks of that clock.
// Notes:   Slot k of a level vector is sampling period k+1.
package sirq_pkg;
  localparam int              CNT_W        = 8;
  localparam int              WIDTH_W      = 4;
  localparam int              SLOT_CNT     = 16;
  localparam int              SLOT_IDX_W   = 4;
  localparam int              NUM_FRAMES   = 17;
  localparam int              START_LOW    = 4;
  localparam int              FRAME_CLKS_I = 3;

  typedef logic [CNT_W-1:0]   sirq_cnt_t;
  typedef logic [WIDTH_W-1:0] sirq_width_t;

  localparam sirq_cnt_t       FRAME_CLKS      = 8'h03;
  localparam sirq_cnt_t       SLOT_LIMIT      = 8'h10;
  localparam sirq_cnt_t       CNT_MAX         = 8'hff;
  localparam sirq_cnt_t       GAP_MIN         = 8'h01;
  localparam sirq_cnt_t       SLAVE_START_CNT = 8'h02;
  localparam sirq_width_t     STOP_QUIET_W    = 4'h2;
  localparam sirq_width_t     STOP_CONT_W     = 4'h3;
  localparam logic [1:0]      PH_SAMPLE       = 2'h2;
  localparam logic [1:0]      PH_RECOV        = 2'h0;
  localparam int              UNUSED_SLOT     = 0;
  localparam int              SMI_SLOT        = 2;
  localparam int              SMI_SERIAL_BIT  = 6;
  localparam int              SMI_PIN_BIT     = 7;

  typedef enum logic [2:0] {
    SL_IDLE   = 3'b001,
    SL_START  = 3'b010,
    SL_FRAMES = 3'b100
  } sirq_slv_state_t;

  typedef enum logic [3:0] {
    HS_IDLE   = 4'b0001,
    HS_START  = 4'b0010,
    HS_FRAMES = 4'b0100,
    HS_STOP   = 4'b1000
  } sirq_hst_state_t;

  // Position 3n-1 after the start rise is the sample clock of frame n.
  function automatic logic [1:0] frame_phase(input sirq_cnt_t pos);
    return 2'(pos % FRAME_CLKS);
  endfunction

  function automatic sirq_cnt_t frame_slot(input sirq_cnt_t pos);
    return pos / FRAME_CLKS;
  endfunction
endpackage

// File: design/sirq_if.sv
// Purpose: Shared open-drain serial interrupt wire between host and slave.
// Assumes: A pull-up holds the wire high when nobody drives it.
// Notes:   Each party gives a drive value and an enable; the wire level is resolved here.
`timescale 1ns/10ps
interface sirq_if;
  logic slave_drv;
  logic slave_oe;
  logic host_drv;
  logic host_oe;
  logic line;

  assign line = (slave_oe ? slave_drv : 1'b1) & (host_oe ? host_drv : 1'b1);

  modport slave (output slave_drv, output slave_oe, input line);
  modport host  (output host_drv, output host_oe, input line);
endinterface

// File: design/sirq_low_meter.sv
// Purpose: Measures each low pulse on the wire and flags its rising edge.
// Assumes: Wire is sampled on every rising clock edge.
// Notes:   Width saturates at its maximum; rise_o is combinational.
`timescale 1ns/10ps
module sirq_low_meter (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  line_i,
  output logic                       rise_o,
  output sirq_pkg::sirq_width_t      width_o
);
  sirq_pkg::sirq_width_t low_cnt_reg;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_reg <= '0;
    end else if (line_i) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != '1) begin
      low_cnt_reg <= low_cnt_reg + 4'h1;
    end
  end

  assign rise_o  = line_i && (low_cnt_reg != '0);
  assign width_o = low_cnt_reg;
endmodule

// File: design/sirq_host.sv
// Purpose: Host controller end of the serial interrupt wire.
// Assumes: One slave on the wire; run_i and quiet_mode_i synchronous.
// Notes:   Collects period levels each cycle; Stop width follows quiet_mode_i.
`timescale 1ns/10ps
module sirq_host #(
  parameter int FRAMES    = sirq_pkg::NUM_FRAMES,
  parameter int START_LOW = sirq_pkg::START_LOW
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  sirq_if.host                               link,
  input  wire logic                          run_i,
  input  wire logic                          quiet_mode_i,
  output logic [sirq_pkg::SLOT_CNT-1:0]      irq_level_o,
  output logic                               cycle_done_o,
  output logic                               quiet_mode_o
);
  localparam sirq_pkg::sirq_cnt_t LAST_POS =
    sirq_pkg::sirq_cnt_t'(sirq_pkg::FRAME_CLKS_I * FRAMES + 1);
  localparam sirq_pkg::sirq_cnt_t START_CNT = sirq_pkg::sirq_cnt_t'(START_LOW);

  sirq_pkg::sirq_hst_state_t       state_reg;
  sirq_pkg::sirq_cnt_t             cnt_reg;
  sirq_pkg::sirq_cnt_t             gap_reg;
  sirq_pkg::sirq_cnt_t             slot;
  sirq_pkg::sirq_width_t           stop_w_reg;
  logic                            oe_reg;
  logic                            drv_reg;

  assign slot = sirq_pkg::frame_slot(cnt_reg);

  // Sequencer: start pulse, frames, Stop pulse; counts are clocks of low or position.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= sirq_pkg::HS_IDLE;
      cnt_reg      <= '0;
      gap_reg      <= sirq_pkg::CNT_MAX;
      oe_reg       <= 1'b0;
      drv_reg      <= 1'b1;
      stop_w_reg   <= sirq_pkg::STOP_CONT_W;
      quiet_mode_o <= 1'b0;
      cycle_done_o <= 1'b0;
    end else begin
      cycle_done_o <= 1'b0;
      unique case (state_reg)
        sirq_pkg::HS_IDLE: begin
          oe_reg  <= 1'b0;
          drv_reg <= 1'b1;
          if (gap_reg != sirq_pkg::CNT_MAX) begin
            gap_reg <= gap_reg + 8'h01;
          end
          if (!link.line) begin
            state_reg <= sirq_pkg::HS_START; // R3
            cnt_reg   <= sirq_pkg::SLAVE_START_CNT;
            oe_reg    <= 1'b1;
            drv_reg   <= 1'b0;
          end else if (run_i && (gap_reg >= sirq_pkg::GAP_MIN)) begin
            state_reg <= sirq_pkg::HS_START; // R6 R8 R21
            cnt_reg   <= 8'h01;
            oe_reg    <= 1'b1;
            drv_reg   <= 1'b0;
          end
        end
        sirq_pkg::HS_START: begin
          if (cnt_reg < START_CNT) begin
            cnt_reg <= cnt_reg + 8'h01; // R3
          end else begin
            drv_reg   <= 1'b1;
            state_reg <= sirq_pkg::HS_FRAMES;
            cnt_reg   <= '0;
          end
        end
        sirq_pkg::HS_FRAMES: begin
          oe_reg  <= 1'b0;
          drv_reg <= 1'b1;
          if (cnt_reg == LAST_POS) begin
            state_reg    <= sirq_pkg::HS_STOP; // R19
            cnt_reg      <= 8'h01;
            oe_reg       <= 1'b1;
            drv_reg      <= 1'b0;
            quiet_mode_o <= quiet_mode_i; // R7
            stop_w_reg   <= quiet_mode_i ? sirq_pkg::STOP_QUIET_W : sirq_pkg::STOP_CONT_W;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        sirq_pkg::HS_STOP: begin
          if (cnt_reg < sirq_pkg::sirq_cnt_t'(stop_w_reg)) begin
            cnt_reg <= cnt_reg + 8'h01;
          end else begin
            drv_reg      <= 1'b1;
            state_reg    <= sirq_pkg::HS_IDLE;
            gap_reg      <= '0;
            cycle_done_o <= 1'b1;
          end
        end
        default: begin
          state_reg <= sirq_pkg::HS_IDLE;
          oe_reg    <= 1'b0;
        end
      endcase
    end
  end

  // Level capture at the sample clocks of periods 1..16.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_level_o <= '1;
    end else if ((state_reg == sirq_pkg::HS_FRAMES)
                 && (sirq_pkg::frame_phase(cnt_reg) == sirq_pkg::PH_SAMPLE)
                 && (slot < sirq_pkg::SLOT_LIMIT)) begin
      irq_level_o[slot[sirq_pkg::SLOT_IDX_W-1:0]] <= link.line; // R23
    end
  end

  assign link.host_oe  = oe_reg;
  assign link.host_drv = drv_reg;
endmodule

// File: bench/sirq_checker.sv
// Purpose: Watches the shared serial interrupt wire between host and slave.
// Assumes: One slave on the wire; the host runs FRAMES frames in each cycle.
// Notes:   Positions count clocks from the rising edge that ends a start pulse.
`timescale 1ns/10ps
module sirq_checker #(
  parameter int FRAMES = 17
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic slave_drv,
  input  wire logic slave_oe,
  input  wire logic host_drv,
  input  wire logic host_oe,
  input  wire logic line
);
  localparam logic [7:0] LAST = 8'(3 * FRAMES + 1);
  logic [7:0] low_cnt_reg;
  logic [7:0] pos_reg;
  logic       quiet_reg;
  wire  logic rise = line && (low_cnt_reg != 8'h00);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) low_cnt_reg <= 8'h00;
    else if (line) low_cnt_reg <= 8'h00;
    else if (low_cnt_reg != 8'hff) low_cnt_reg <= low_cnt_reg + 8'h01;
  end

  // A low run of four or more clocks is a start pulse; its rise is position 0.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) pos_reg <= 8'hff;
    else if (rise && low_cnt_reg >= 8'h04) pos_reg <= 8'h01;
    else if (pos_reg != 8'hff) pos_reg <= pos_reg + 8'h01;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) quiet_reg <= 1'b0;
    else if (rise && low_cnt_reg == 8'h02) quiet_reg <= 1'b1;
    else if (rise && low_cnt_reg == 8'h03) quiet_reg <= 1'b0;
  end

  property p_rst_rel; $past(rst_i) |-> !slave_oe && !host_oe; endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("wire driven at reset release");
  property p_low_width; rise |-> low_cnt_reg inside {[8'h01:8'h04]}; endproperty
  a_low_width: assert property (p_low_width)
    else $error("low pulse too long");
  property p_stop_width;
    rise && pos_reg > LAST && pos_reg < LAST + 8'h05 |-> low_cnt_reg inside {8'h02, 8'h03};
  endproperty
  a_stop_width: assert property (p_stop_width)
    else $error("stop pulse width wrong");
  property p_recov;
    slave_oe && !slave_drv |=> (slave_oe && slave_drv) || (!slave_oe && host_oe && !host_drv);
  endproperty
  a_recov: assert property (p_recov)
    else $error("slave low not followed by recovery or host takeover");
  property p_turn; slave_oe && slave_drv |=> !slave_oe; endproperty
  a_turn: assert property (p_turn)
    else $error("slave high held past recovery");
  property p_sample;
    slave_oe && !slave_drv && pos_reg <= LAST |->
      pos_reg % 8'h03 == 8'h02 && pos_reg >= 8'h05 && pos_reg <= 8'h2f;
  endproperty
  a_sample: assert property (p_sample)
    else $error("slave low outside a sample slot");
  property p_slv_start;
    slave_oe && !slave_drv && pos_reg > LAST |-> quiet_reg && $past(line) && $past(line, 2);
  endproperty
  a_slv_start: assert property (p_slv_start)
    else $error("slave start not allowed here");
  property p_host_start;
    host_oe && !host_drv && !$past(host_oe) && $past(line) && pos_reg > LAST + 8'h03
      |-> $past(line, 2);
  endproperty
  a_host_start: assert property (p_host_start)
    else $error("host start too soon after stop");
  property p_host_rel; host_oe && host_drv |=> !host_oe; endproperty
  a_host_rel: assert property (p_host_rel)
    else $error("host high held longer than one clock");
endmodule

// File: bench/tb.sv
// Purpose: Runs host and slave against each other and checks reported levels.
// Assumes: Host built with 17 frames and a four-clock start pulse.
// Notes:   Levels are checked after a full cycle with stable inputs, and once during reset.
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] irq_lvl = 16'hffff;
  logic        req_n = 1'b1;
  logic [7:0]  en2 = 8'h00;
  logic        run = 1'b0;
  logic        quiet = 1'b0;
  logic [15:0] lvl_seen;
  logic        mgmt_n;
  logic        slv_quiet;
  logic        act;
  logic        done;
  logic        hst_quiet;
  int          mismatches = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  sirq_if sirq_if_i ();
  sirq_slave sirq_slave_i (.sys_clk_i(clk), .rst_i(rst), .link(sirq_if_i.slave),
    .irq_level_i(irq_lvl), .mgmt_interrupt_request_n_i(req_n), .mgmt_enable2_i(en2),
    .mgmt_interrupt_n_o(mgmt_n), .quiet_mode_o(slv_quiet), .cycle_active_o(act));
  sirq_host #(.FRAMES(17), .START_LOW(4)) sirq_host_i (.sys_clk_i(clk), .rst_i(rst),
    .link(sirq_if_i.host), .run_i(run), .quiet_mode_i(quiet), .irq_level_o(lvl_seen),
    .cycle_done_o(done), .quiet_mode_o(hst_quiet));
  sirq_checker #(.FRAMES(17)) sirq_checker_i (.sys_clk_i(clk), .rst_i(rst),
    .slave_drv(sirq_if_i.slave_drv), .slave_oe(sirq_if_i.slave_oe),
    .host_drv(sirq_if_i.host_drv), .host_oe(sirq_if_i.host_oe), .line(sirq_if_i.line));

  // Period 1 is never driven, and period 3 carries the request when routed there.
  function automatic logic [15:0] exp_lvl(input logic [15:0] l, input logic r,
                                          input logic [7:0] e);
    logic [15:0] v;
    v = l;
    v[0] = 1'b1;
    if (e[6]) v[2] = r;
    return v;
  endfunction

  task automatic close_out();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic clocks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wdone();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    if (n >= 400) begin
      mismatches++;
      $display("BAD %0t no cycle end", $time);
      close_out();
    end
  endtask

  initial begin
    void'($urandom(32'h8f0e59a9));
    clocks(6);
    rst <= 1'b0;
    run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wdone();
      irq_lvl <= (i == 0) ? 16'h0000 : (i == 1) ? 16'hdfff : 16'($urandom);
      req_n <= 1'($urandom);
      en2 <= 8'($urandom);
      wdone();
      wdone();
      chk(lvl_seen, exp_lvl(irq_lvl, req_n, en2));
      chk({15'h0000, mgmt_n}, {15'h0000, ~en2[7] | req_n});
      chk({14'h0000, slv_quiet, hst_quiet}, 16'h0000);
    end
    wdone();
    quiet <= 1'b1;
    clocks(10);
    chk({13'h0000, slv_quiet, hst_quiet, act}, 16'h0001);
    wdone();
    run <= 1'b0;
    en2 <= 8'h80;
    clocks(3);
    chk({14'h0000, slv_quiet, hst_quiet}, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      irq_lvl <= irq_lvl ^ (16'h0001 << (1 + $urandom_range(14, 0)));
      wdone();
      clocks(3);
      chk(lvl_seen, exp_lvl(irq_lvl, req_n, en2));
    end
    quiet <= 1'b0;
    run <= 1'b1;
    wdone();
    wdone();
    run <= 1'b0;
    clocks(3);
    chk({15'h0000, slv_quiet}, 16'h0000);
    irq_lvl <= ~irq_lvl;
    clocks(40);
    chk({15'h0000, act}, 16'h0000);
    run <= 1'b1;
    wdone();
    wdone();
    chk(lvl_seen, exp_lvl(irq_lvl, req_n, en2));
    clocks(20);
    rst <= 1'b1;
    clocks(2);
    chk({13'h0000, sirq_if_i.slave_oe, sirq_if_i.host_oe, act}, 16'h0000);
    chk(lvl_seen, 16'hffff);
    rst <= 1'b0;
    wdone();
    wdone();
    chk(lvl_seen, exp_lvl(irq_lvl, req_n, en2));
    close_out();
  end
endmodule
